/* File: frct_pulse_src.sv */
/* capture pulse source for the timer; the pin_load input is left unused.
   assumes fire is driven on the rising edge of clk by the bench. */
module frct_pulse_src (
  input wire logic clk,
  input wire logic [3:0] fire,
  input wire logic [3:0] pin_load,
  output logic [3:0] pin_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin_drive = 4'h0;
  // one fire pulse gives one level change
  always @(posedge clk) begin
    pin_drive <= pin_drive ^ fire;
  end
endmodule // frct_pulse_src

/* File: frct_regs.vh */
/*
 * register map, field positions, reset values and codes of the
 * free-running capture/compare timer.
 * assumes byte addresses on a 32-bit avalon-mm slave, one word each.
 */
`ifndef FRCT_REGS_VH
`define FRCT_REGS_VH

// byte offsets
`define FRCT_CTRL_OFS 6'h00
`define FRCT_OPTION_OFS 6'h04
`define FRCT_OUTCTL_OFS 6'h08
`define FRCT_EDGESEL_OFS 6'h0c
`define FRCT_CHVAL0_OFS 6'h10
`define FRCT_CHVAL1_OFS 6'h14
`define FRCT_CHVAL2_OFS 6'h18
`define FRCT_CHVAL3_OFS 6'h1c
`define FRCT_COUNT_OFS 6'h20
`define FRCT_STATUS_OFS 6'h24
`define FRCT_MASK_OFS 6'h28
`define FRCT_FLAGCLR_OFS 6'h2c

// channel value registers sit in this 16-byte window
`define FRCT_CHVAL_WIN 2'h1

// control register fields
`define FRCT_MODE_MSB 2
`define FRCT_MODE_LSB 0
`define FRCT_CE_BIT 7
`define FRCT_MODE_FREERUN 3'h5

// option register fields
`define FRCT_WRAP_BIT 0
`define FRCT_SEL_LSB 1

// edge select codes, two bits per capture input
`define FRCT_EDGE_NONE 2'h0
`define FRCT_EDGE_RISE 2'h1
`define FRCT_EDGE_FALL 2'h2
`define FRCT_EDGE_BOTH 2'h3

// status and mask bit of the counter wrap
`define FRCT_STAT_WRAP_BIT 4

// reset values and counter limits
`define FRCT_REG8_RST 8'h00
`define FRCT_VAL_RST 16'h0000
`define FRCT_CNT_MAX 16'hffff
`define FRCT_CNT_ZERO 16'h0000
`define FRCT_CNT_STEP 16'h0001

`endif

/* File: frct_timer.v */
/*
 * free-running 16-bit timer with four capture/compare channels,
 * sticky wrap flag, output pin control and a masked interrupt.
 * assumes an avalon-mm master with waitrequest on CLK, and capture
 * pins that are asynchronous to CLK; the count clock is CLK gated
 * by CLK_EN.
 */
`include "frct_regs.vh"

// Contract
// - free-running operation only when the mode field holds code 101.
// - count enable starts counting; each channel is compare or capture.
// - when counting starts, every enabled compare output pin inverts.
// - compare equal raises channel interrupt and inverts its pin.
// - counter increments, wraps ffff to 0000 raising wrap interrupt.
// - each wrap sets the sticky wrap flag until software clears it.
// - compare register writes act immediately, without buffering.
// - selected capture edge copies counter to channel, raises interrupt.
// - each capture input has its own edge select field.
// - disabled output drives its idle level bit.
// - wrap flag clears by bit-clear or option write with bit 0 low.
// - bit-clear coinciding with a wrap leaves the flag set.
// - enabled output holds idle level, then opposite once counting; enabled capture channel outputs stay at idle level.
module frct_timer (
  input wire CLK,
  input wire RST,
  input wire CLK_EN,
  input wire [5:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] WRITEDATA,
  input wire [3:0] BYTEENABLE,
  output wire [31:0] READDATA,
  output wire WAITREQUEST,
  input wire [3:0] CAPTURE_INPUT_PIN,
  output wire [3:0] TIMER_OUTPUT_PIN,
  output wire [3:0] CHANNEL_EVENT_IRQ,
  output wire WRAP_IRQ,
  output wire IRQ
);

  reg ack_r;
  reg ack_nxt;
  reg [31:0] rdata_r;
  reg [31:0] rd_nxt;
  reg [7:0] ctrl_r;
  reg [7:0] ctrl_nxt;
  reg [7:0] option_r;
  reg [7:0] option_nxt;
  reg [7:0] outctl_r;
  reg [7:0] outctl_nxt;
  reg [7:0] edgesel_r;
  reg [7:0] edgesel_nxt;
  reg [7:0] mask_r;
  reg [7:0] mask_nxt;
  reg [4:0] status_r;
  reg [4:0] status_nxt;
  reg [15:0] count_r;
  reg [15:0] count_nxt;
  reg run_prev_r;
  reg [3:0] chirq_r;
  reg wrap_irq_r;
  reg wrap_flag_nxt;

  wire [63:0] chval_w;
  wire [3:0] ev_w;
  wire [3:0] pin_w;
  wire [4:0] ev_all;
  wire [4:0] irq_pend;
  wire [15:0] count_inc;
  wire [5:0] wa;
  wire req;
  wire acc;
  wire wr_acc;
  wire rd_acc;
  wire rd_status;
  wire running;
  wire start;
  wire cnt_top;
  wire wrap;
  wire wr_ctrl;
  wire wr_option;
  wire wr_outctl;
  wire wr_edgesel;
  wire wr_mask;
  wire wr_flagclr;
  wire wrap_clr;
  wire [4:0] stat_clr;

  // bus handshake: one wait cycle, answer on the second
  assign req = READ | WRITE;
  assign WAITREQUEST = req & ~(ack_r & CLK_EN);
  assign acc = req & ack_r & CLK_EN;
  assign wr_acc = WRITE & acc;
  assign rd_acc = READ & acc;
  assign wa = {ADDRESS[5:2], 2'b00};
  assign READDATA = rdata_r;

  // ack every other enabled cycle; read data taken up front
  always @* begin
    ack_nxt = req & ~ack_r;
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else if (CLK_EN) begin
      ack_r <= ack_nxt;
      if (READ & ~ack_r)
        rdata_r <= rd_nxt;
    end
  end

  // register write strobes
  assign wr_ctrl = wr_acc & (wa == `FRCT_CTRL_OFS) & BYTEENABLE[0];
  assign wr_option = wr_acc & (wa == `FRCT_OPTION_OFS) & BYTEENABLE[0];
  assign wr_outctl = wr_acc & (wa == `FRCT_OUTCTL_OFS) & BYTEENABLE[0];
  assign wr_edgesel = wr_acc & (wa == `FRCT_EDGESEL_OFS) & BYTEENABLE[0];
  assign wr_mask = wr_acc & (wa == `FRCT_MASK_OFS) & BYTEENABLE[0];
  assign wr_flagclr = wr_acc & (wa == `FRCT_FLAGCLR_OFS) & BYTEENABLE[0]
    & WRITEDATA[0];

  // counting state
  assign running = ctrl_r[`FRCT_CE_BIT]
    & (ctrl_r[`FRCT_MODE_MSB:`FRCT_MODE_LSB] == `FRCT_MODE_FREERUN);
  assign start = running & ~run_prev_r;
  assign cnt_top = (count_r == `FRCT_CNT_MAX);
  assign wrap = running & cnt_top;
  assign count_inc = count_r + `FRCT_CNT_STEP;
  assign ev_all = {wrap, ev_w};

  // next count: zero while stopped, wraps after the top
  always @* begin
    count_nxt = count_inc;
    if (!running) begin
      count_nxt = `FRCT_CNT_ZERO;
    end else if (wrap) begin
      count_nxt = `FRCT_CNT_ZERO;
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      count_r <= `FRCT_CNT_ZERO;
      run_prev_r <= 1'b0;
    end else if (CLK_EN) begin
      run_prev_r <= running;
      count_r <= count_nxt;
    end
  end

  // per-channel capture, compare and output pin
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_ch
      localparam [1:0] IDX = i;
      reg [2:0] sync_r;
      reg [15:0] val_r;
      reg [15:0] val_nxt;
      reg tog_r;
      reg tog_nxt;
      reg pin_r;
      reg pin_nxt;
      reg edge_hit;
      wire [1:0] esel;
      wire is_cap;
      wire cmp_start;
      wire rise;
      wire fall;
      wire cap;
      wire match;
      wire wr_val;

      assign esel = edgesel_r[2*i+1:2*i];
      assign is_cap = option_r[`FRCT_SEL_LSB+i];
      assign cmp_start = start & ~is_cap;
      // two sync flops, then an edge flop
      assign rise = sync_r[1] & ~sync_r[2];
      assign fall = ~sync_r[1] & sync_r[2];
      assign cap = running & is_cap & edge_hit;
      assign match = running & ~is_cap & (count_r == val_r);
      assign wr_val = wr_acc & (wa[5:4] == `FRCT_CHVAL_WIN)
        & (wa[3:2] == IDX);
      assign ev_w[i] = cap | match;
      assign chval_w[16*i+15:16*i] = val_r;
      assign pin_w[i] = pin_r;

      // valid edge decode per capture input
      always @* begin
        case (esel)
          `FRCT_EDGE_NONE: edge_hit = 1'b0;
          `FRCT_EDGE_RISE: edge_hit = rise;
          `FRCT_EDGE_FALL: edge_hit = fall;
          `FRCT_EDGE_BOTH: edge_hit = rise | fall;
          default: edge_hit = 1'b0;
        endcase
      end

      // capture beats a same-cycle write; writes act at once
      always @* begin
        val_nxt = val_r;
        if (cap) begin
          val_nxt = count_r;
        end else if (wr_val) begin
          if (BYTEENABLE[0])
            val_nxt[7:0] = WRITEDATA[7:0];
          if (BYTEENABLE[1])
            val_nxt[15:8] = WRITEDATA[15:8];
        end
      end

      // toggle: cleared when stopped, flips at start and match in compare mode
      always @* begin
        tog_nxt = tog_r;
        if (!running) begin
          tog_nxt = 1'b0;
        end else if (cmp_start | match) begin
          tog_nxt = ~tog_r;
        end
        // idle level, inverted by the toggle when enabled
        pin_nxt = outctl_r[2*i+1] ^ (outctl_r[2*i] & tog_r);
      end

      always @(posedge CLK or posedge RST) begin
        if (RST) begin
          sync_r <= 3'h0;
          val_r <= `FRCT_VAL_RST;
          tog_r <= 1'b0;
          pin_r <= 1'b0;
        end else if (CLK_EN) begin
          sync_r <= {sync_r[1:0], CAPTURE_INPUT_PIN[i]};
          val_r <= val_nxt;
          tog_r <= tog_nxt;
          pin_r <= pin_nxt;
        end
      end
    end
  endgenerate

  assign TIMER_OUTPUT_PIN = pin_w;

  // wrap flag: bit-clear or option write with bit 0 low, set always wins
  assign wrap_clr = wr_flagclr | (wr_option & ~WRITEDATA[0]);

  // status clears only the bits that the read returned
  assign rd_status = rd_acc & (wa == `FRCT_STATUS_OFS);
  assign stat_clr = rd_status ? rdata_r[4:0] : 5'h00;

  // next values of the plain software registers
  always @* begin
    ctrl_nxt = ctrl_r;
    outctl_nxt = outctl_r;
    edgesel_nxt = edgesel_r;
    mask_nxt = mask_r;
    if (wr_ctrl) begin
      ctrl_nxt = WRITEDATA[7:0];
    end
    if (wr_outctl) begin
      outctl_nxt = WRITEDATA[7:0];
    end
    if (wr_edgesel) begin
      edgesel_nxt = WRITEDATA[7:0];
    end
    if (wr_mask) begin
      mask_nxt = WRITEDATA[7:0];
    end
  end

  // option: function bits by write, wrap flag sticky
  always @* begin
    option_nxt = option_r;
    wrap_flag_nxt = option_r[`FRCT_WRAP_BIT];
    if (wr_option) begin
      option_nxt = WRITEDATA[7:0];
      wrap_flag_nxt = WRITEDATA[0];
    end
    if (wrap_clr) begin
      wrap_flag_nxt = 1'b0;
    end
    if (wrap) begin
      wrap_flag_nxt = 1'b1;
    end
    option_nxt[`FRCT_WRAP_BIT] = wrap_flag_nxt;
  end

  // status: events set, a status read clears what it returned
  always @* begin
    status_nxt = (status_r & ~stat_clr) | ev_all;
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= `FRCT_REG8_RST;
      option_r <= `FRCT_REG8_RST;
      outctl_r <= `FRCT_REG8_RST;
      edgesel_r <= `FRCT_REG8_RST;
      mask_r <= `FRCT_REG8_RST;
      status_r <= 5'h00;
      chirq_r <= 4'h0;
      wrap_irq_r <= 1'b0;
    end else if (CLK_EN) begin
      ctrl_r <= ctrl_nxt;
      option_r <= option_nxt;
      outctl_r <= outctl_nxt;
      edgesel_r <= edgesel_nxt;
      mask_r <= mask_nxt;
      status_r <= status_nxt;
      chirq_r <= ev_w;
      wrap_irq_r <= wrap;
    end
  end

  // interrupt outputs
  assign CHANNEL_EVENT_IRQ = chirq_r;
  assign WRAP_IRQ = wrap_irq_r;
  assign irq_pend = status_r & mask_r[4:0];
  assign IRQ = |irq_pend;

  // read data selection
  always @* begin
    rd_nxt = 32'h00000000;
    case (wa)
      `FRCT_CTRL_OFS: rd_nxt = {24'h000000, ctrl_r};
      `FRCT_OPTION_OFS: rd_nxt = {24'h000000, option_r};
      `FRCT_OUTCTL_OFS: rd_nxt = {24'h000000, outctl_r};
      `FRCT_EDGESEL_OFS: rd_nxt = {24'h000000, edgesel_r};
      `FRCT_CHVAL0_OFS: rd_nxt = {16'h0000, chval_w[15:0]};
      `FRCT_CHVAL1_OFS: rd_nxt = {16'h0000, chval_w[31:16]};
      `FRCT_CHVAL2_OFS: rd_nxt = {16'h0000, chval_w[47:32]};
      `FRCT_CHVAL3_OFS: rd_nxt = {16'h0000, chval_w[63:48]};
      `FRCT_COUNT_OFS: rd_nxt = {16'h0000, count_r};
      `FRCT_STATUS_OFS: rd_nxt = {27'h0000000, status_r};
      `FRCT_MASK_OFS: rd_nxt = {24'h000000, mask_r};
      default: rd_nxt = 32'h00000000;
    endcase
  end

endmodule // frct_timer

/* File: frct_timer_props.sv */
/* bus, pulse and interrupt checks of the timer.
   assumes binding to the top module ports. */
module frct_timer_props (
  input wire CLK,
  input wire RST,
  input wire CLK_EN,
  input wire READ,
  input wire WRITE,
  input wire [31:0] READDATA,
  input wire WAITREQUEST,
  input wire [3:0] CHANNEL_EVENT_IRQ,
  input wire WRAP_IRQ,
  input wire IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  wire req = READ | WRITE;
  a_one_wait: assert property (
    req && WAITREQUEST && CLK_EN |=> !WAITREQUEST || !CLK_EN)
    else $error("wait longer than one cycle");
  a_no_idle_wait: assert property (WAITREQUEST |-> req)
    else $error("wait without request");
  a_wait_first: assert property (req && !WAITREQUEST |-> $past(WAITREQUEST))
    else $error("answer without wait cycle");
  a_rdata_narrow: assert property (READDATA[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_rdata_hold: assert property (
    !(READ && WAITREQUEST) |=> $stable(READDATA))
    else $error("read data changed without read");
  a_wrap_pulse: assert property (WRAP_IRQ |=> !WRAP_IRQ)
    else $error("wrap pulse too long");
  a_event_pulse: assert property (
    CHANNEL_EVENT_IRQ[0] |=> !CHANNEL_EVENT_IRQ[0])
    else $error("event pulse too long");
  a_irq_fall_bus: assert property (
    $fell(IRQ) |-> $past(req && !WAITREQUEST))
    else $error("irq fell without access");
  cover property (WRAP_IRQ);
  cover property (CHANNEL_EVENT_IRQ[1]);
  cover property ($fell(IRQ));
endmodule // frct_timer_props
bind frct_timer frct_timer_props u_props (.CLK(CLK), .RST(RST),
  .CLK_EN(CLK_EN), .READ(READ), .WRITE(WRITE), .READDATA(READDATA),
  .WAITREQUEST(WAITREQUEST), .CHANNEL_EVENT_IRQ(CHANNEL_EVENT_IRQ),
  .WRAP_IRQ(WRAP_IRQ), .IRQ(IRQ));

/* File: tb_top.sv */
/* self-checking bench of the capture/compare timer.
   assumes the timer, its checker and the pulse source model. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, RST = 1, CLK_EN = 1, READ = 0, WRITE = 0, seen = 0;
  logic [5:0] ADDRESS = 0;
  logic [31:0] WRITEDATA = 0, READDATA, rd;
  logic [3:0] BYTEENABLE = 4'hf, fire = 0, cin, pins, ev;
  logic WAITREQUEST, WRAP_IRQ, IRQ;
  logic [15:0] c0, cap1;
  int bad_count = 0, total_checks = 0, cyc = 0;
  int wraps = 0, tp = 0, t1 = 0, w1 = 0;
  wire [4:0] evs = {WRAP_IRQ, ev};
  logic [5:0] ta [9] = '{6'h08, 6'h0c, 6'h10, 6'h1c, 6'h28, 6'h30, 6'h2c,
    6'h20, 6'h04};
  logic [31:0] tw [9] = '{32'h1ff, 32'h4, 32'h11234, 32'hfffe, 32'h10,
    32'hffff, 32'h0, 32'h5, 32'h4};
  logic [31:0] te [9] = '{32'hff, 32'h4, 32'h1234, 32'hfffe, 32'h10,
    32'h0, 32'h0, 32'h0, 32'h4};
  frct_timer DUT (.CLK(CLK), .RST(RST), .CLK_EN(CLK_EN), .ADDRESS(ADDRESS),
    .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .CAPTURE_INPUT_PIN(cin),
    .TIMER_OUTPUT_PIN(pins), .CHANNEL_EVENT_IRQ(ev), .WRAP_IRQ(WRAP_IRQ),
    .IRQ(IRQ));
  frct_pulse_src src (.clk(CLK), .fire(fire), .pin_load(pins),
    .pin_drive(cin));
  initial forever #2 CLK = ~CLK;
  // software wrap counter, kept for the measuring channel
  always @(posedge CLK) begin
    if (WRAP_IRQ === 1'b1)
      wraps <= wraps + 1;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      results;
    end
  end
  task automatic results;
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [5:0] a,
      input logic [31:0] d);
    @(posedge CLK);
    ADDRESS <= a;
    WRITEDATA <= d;
    WRITE <= w;
    READ <= !w;
    do @(posedge CLK); while (WAITREQUEST !== 1'b0);
    rd = READDATA;
    WRITE <= 0;
    READ <= 0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic hunt(input int k, input int lim);
    seen = 0;
    for (int i = 0; i < lim && seen !== 1'b1; i++) begin
      @(negedge CLK);
      seen = evs[k];
    end
  endtask
  task automatic pulse;
    @(posedge CLK);
    tp = cyc;
    fire <= 4'h2;
    @(posedge CLK);
    fire <= 0;
    hunt(1, 20);
  endtask
  initial begin
    repeat (5) @(posedge CLK);
    RST <= 0;
    @(negedge CLK);
    chk("reset", 0, {pins, ev, WRAP_IRQ, IRQ});
    foreach (ta[i]) begin
      acc(1, ta[i], tw[i]);
      acc(0, ta[i], 0);
      chk("reg", te[i], rd);
    end
    acc(1, 6'h08, 32'haa);
    repeat (3) @(negedge CLK);
    chk("idle_hi", 4'hf, pins);
    acc(1, 6'h08, 32'h55);
    repeat (3) @(negedge CLK);
    chk("en_idle_lo", 0, pins);
    acc(1, 6'h08, 32'hff);
    acc(1, 6'h00, 32'h84);
    repeat (4) @(negedge CLK);
    acc(0, 6'h20, 0);
    chk("no_mode", {4'hf, 16'h0}, {pins, rd[15:0]});
    acc(1, 6'h00, 32'h85);
    repeat (4) @(negedge CLK);
    chk("start_flip", {4'h2, 1'b0}, {pins, IRQ});
    acc(0, 6'h20, 0);
    acc(1, 6'h10, rd + 32'h40);
    hunt(0, 200);
    repeat (3) @(negedge CLK);
    chk("match", {1'b1, 4'h3}, {seen, pins});
    acc(0, 6'h24, 0);
    chk("status", 32'h5, rd);
    acc(0, 6'h24, 0);
    chk("status_clr", 0, rd);
    acc(0, 6'h20, 0);
    c0 = rd[15:0];
    pulse;
    acc(0, 6'h14, 0);
    chk("capture", 1, seen && rd[15:0] > c0 && rd[15:0] < c0 + 16'h20);
    t1 = tp;
    cap1 = rd[15:0];
    w1 = wraps;
    pulse;
    chk("fall_ignored", 0, seen);
    hunt(4, 70000);
    repeat (2) @(negedge CLK);
    chk("wrap_irq", {1'b1, 1'b1}, {seen, IRQ});
    acc(0, 6'h24, 0);
    chk("wrap_stat", 32'h1e, rd);
    @(negedge CLK);
    chk("irq_off", 0, IRQ);
    acc(0, 6'h04, 0);
    chk("flag_sticky", 32'h5, rd);
    acc(1, 6'h2c, 32'h1);
    acc(0, 6'h04, 0);
    chk("flag_clr", 32'h4, rd);
    pulse;
    acc(0, 6'h14, 0);
    chk("width", tp - t1, (wraps - w1) * 32'h10000 + rd[15:0] - cap1);
    acc(0, 6'h20, 0);
    c0 = rd[15:0];
    CLK_EN <= 0;
    repeat (20) @(posedge CLK);
    CLK_EN <= 1;
    acc(0, 6'h20, 0);
    chk("freeze", 16'h3, rd[15:0] - c0);
    RST <= 1;
    repeat (2) @(posedge CLK);
    RST <= 0;
    @(negedge CLK);
    chk("reset_mid", 0, {pins, ev, WRAP_IRQ, IRQ});
    acc(0, 6'h04, 0);
    chk("option_rst", 0, rd);
    results;
  end
endmodule // tb_top
